// file: src/spa_top.sv
// Search path accelerator with its host byte FIFO
`include "spa_defines.svh"

// Byte FIFO with registered input ready
module spa_fifo #(
   parameter int W  = `SPA_FIFO_W,
   parameter int D  = `SPA_FIFO_D,
   parameter int AW = `SPA_FIFO_AW
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Fill side
   input  wire logic          in_valid,
   input  wire logic [W-1:0]  in_data,
   output logic               in_ready,
   // Drain side
   output logic               out_valid,
   output logic [W-1:0]       out_data,
   input  wire logic          out_ready
);
   logic [W-1:0] mem [D];      // Storage
   logic [AW-1:0] wp_r, wp_nxt; // Write pointer
   logic [AW-1:0] rp_r, rp_nxt; // Read pointer
   logic [AW:0]   cnt_r, cnt_nxt; // Fill level
   logic          rdy_r, rdy_nxt; // Registered not-full
   logic          push, pop;

   assign push      = in_valid && rdy_r;
   assign pop       = out_ready && (cnt_r != '0);
   assign in_ready  = rdy_r;
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rp_r];

   // Pointer and level arithmetic
   always_comb begin
      wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
      rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
      cnt_nxt = (AW+1)'(cnt_r + {AW'(0), push} - {AW'(0), pop});
      rdy_nxt = (cnt_nxt != (AW+1)'(D));
   end

   // Registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
         rdy_r <= 1'b1;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
         rdy_r <= rdy_nxt;
      end
   end

   // Storage has no reset; only written entries are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end
endmodule

// Operation
// - Accelerator on: data byte becomes twelve slots
// - Control command bit 4 sets flag, silent
// - One answer byte per data byte
// - Odd bits are paths, even bits filler
// - Host path used only on conflict
// - Per position: read, read, write slot
// - Write path, first read, or one
// - Answer: even discrepancy, odd chosen path
// - Discrepancy on conflict or no response
// - Reported path equals written slot value
// - After error, paths read one until off
// - Reset answered, mode bytes silent, data echoed with accelerator off
module spa_top (
   // Clock and reset
   input  wire logic              REF_CLK,
   input  wire logic              RESET_N,
   // Host bytes from the serial receiver
   input  wire logic              HOST_VALID,
   input  wire logic [7:0]        HOST_DATA,
   output logic                   HOST_READY,
   // Answer bytes to the serial transmitter
   output logic                   RESP_VALID,
   output logic [7:0]             RESP_DATA,
   input  wire logic              RESP_READY,
   // Slot engine handshake
   output logic                   SLOT_START,
   output spa_pkg::spa_slot_t     SLOT_REQ,
   input  wire logic              SLOT_DONE,
   input  wire logic              SLOT_RBIT,
   input  wire logic [1:0]        SLOT_PRES,
   // Status
   output logic                   ACCEL_ON,
   output logic                   DATA_MODE
);
   spa_pkg::spa_state_t st_r, st_nxt;     // Sequencer state
   spa_pkg::spa_slot_t  slot_r, slot_nxt; // Current slot request
   logic       start_r, start_nxt;        // Slot start pulse
   logic       acc_r, acc_nxt;            // Accelerator flag
   logic       dm_r, dm_nxt;              // Data mode
   logic       err_r, err_nxt;            // Sticky bus error
   logic [7:0] byte_r, byte_nxt;          // Host byte in work
   logic [7:0] sh_r, sh_nxt;              // Answer being built
   logic [1:0] pos_r, pos_nxt;            // Position within byte
   logic [1:0] ph_r, ph_nxt;              // Slot phase of a position
   logic [2:0] bit_r, bit_nxt;            // Bit of a plain byte
   logic       rd0_r, rd0_nxt;            // First read value
   logic       rv_r, rv_nxt;              // Answer valid
   logic [7:0] rd_r, rd_nxt;              // Answer byte
   logic       f_valid, f_ready;          // FIFO drain side
   logic [7:0] f_data;
   logic       conf, noresp, wval;        // Position decision

   // Host bytes wait here while slots run
   spa_fifo #(.W(`SPA_FIFO_W), .D(`SPA_FIFO_D), .AW(`SPA_FIFO_AW)) u_fifo (
      .clk       (REF_CLK),
      .rst_n     (RESET_N),
      .in_valid  (HOST_VALID),
      .in_data   (HOST_DATA),
      .in_ready  (HOST_READY),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (f_ready)
   );

   // Only pull a byte when idle, which stalls the FIFO otherwise
   assign f_ready = (st_r == spa_pkg::SPA_S_IDLE);

   // Position decision from both reads
   always_comb begin
      conf   = !rd0_r && !SLOT_RBIT;
      noresp = rd0_r && SLOT_RBIT;
      if (err_r || noresp) begin
         wval = 1'b1;
      end else if (conf) begin
         wval = byte_r[{pos_r, 1'b1}];
      end else begin
         wval = rd0_r;
      end
   end

   // Next-state logic of the sequencer
   always_comb begin
      st_nxt    = st_r;
      slot_nxt  = slot_r;
      start_nxt = 1'b0;
      acc_nxt   = acc_r;
      dm_nxt    = dm_r;
      err_nxt   = err_r;
      byte_nxt  = byte_r;
      sh_nxt    = sh_r;
      pos_nxt   = pos_r;
      ph_nxt    = ph_r;
      bit_nxt   = bit_r;
      rd0_nxt   = rd0_r;
      rv_nxt    = rv_r;
      rd_nxt    = rd_r;
      unique case (st_r)
         spa_pkg::SPA_S_IDLE: begin
            if (f_valid && !dm_r) begin
               // Command mode: mode switch, accelerator and reset codes
               if (f_data == `SPA_CMD_DATA) begin
                  dm_nxt = 1'b1;
               end else if ((f_data & `SPA_CMD_MASK) == `SPA_ACC_VAL) begin
                  acc_nxt = f_data[`SPA_ACC_BIT];
                  if (!f_data[`SPA_ACC_BIT]) begin
                     err_nxt = 1'b0;
                  end
               end else if ((f_data & `SPA_CMD_MASK) == `SPA_RST_VAL) begin
                  slot_nxt  = '{kind: spa_pkg::SPA_K_RESET, wbit: 1'b1};
                  start_nxt = 1'b1;
                  st_nxt    = spa_pkg::SPA_S_SLOT;
               end
            end else if (f_valid) begin
               if (f_data == `SPA_CMD_CMD) begin
                  dm_nxt = 1'b0;
               end else begin
                  byte_nxt  = f_data;
                  pos_nxt   = '0;
                  ph_nxt    = '0;
                  bit_nxt   = '0;
                  start_nxt = 1'b1;
                  st_nxt    = spa_pkg::SPA_S_SLOT;
                  if (acc_r) begin
                     slot_nxt = '{kind: spa_pkg::SPA_K_READ, wbit: 1'b1};
                  end else begin
                     slot_nxt = '{kind: spa_pkg::SPA_K_WRITE, wbit: f_data[0]};
                  end
               end
            end
         end
         spa_pkg::SPA_S_SLOT: begin
            if (SLOT_DONE) begin
               if (slot_r.kind == spa_pkg::SPA_K_RESET) begin
                  rd_nxt = {`SPA_RST_HEAD, SLOT_PRES};
                  rv_nxt = 1'b1;
                  st_nxt = spa_pkg::SPA_S_RESP;
               end else if (!acc_r) begin
                  // Plain byte: LSB first, read-back forms the echo
                  sh_nxt = {SLOT_RBIT, sh_r[7:1]};
                  if (bit_r == `SPA_BIT_LAST) begin
                     rd_nxt = {SLOT_RBIT, sh_r[7:1]};
                     rv_nxt = 1'b1;
                     st_nxt = spa_pkg::SPA_S_RESP;
                  end else begin
                     bit_nxt   = 3'(bit_r + 1'b1);
                     slot_nxt  = '{kind: spa_pkg::SPA_K_WRITE, wbit: byte_r[3'(bit_r + 1'b1)]};
                     start_nxt = 1'b1;
                  end
               end else if (ph_r == 2'h0) begin
                  rd0_nxt   = SLOT_RBIT;
                  ph_nxt    = 2'h1;
                  slot_nxt  = '{kind: spa_pkg::SPA_K_READ, wbit: 1'b1};
                  start_nxt = 1'b1;
               end else if (ph_r == 2'h1) begin
                  sh_nxt[{pos_r, 1'b0}] = conf || noresp;
                  sh_nxt[{pos_r, 1'b1}] = wval;
                  err_nxt   = err_r || noresp;
                  ph_nxt    = 2'h2;
                  slot_nxt  = '{kind: spa_pkg::SPA_K_WRITE, wbit: wval};
                  start_nxt = 1'b1;
               end else begin
                  ph_nxt = 2'h0;
                  if (pos_r == `SPA_POS_LAST) begin
                     rd_nxt = sh_r;
                     rv_nxt = 1'b1;
                     st_nxt = spa_pkg::SPA_S_RESP;
                  end else begin
                     pos_nxt   = 2'(pos_r + 1'b1);
                     slot_nxt  = '{kind: spa_pkg::SPA_K_READ, wbit: 1'b1};
                     start_nxt = 1'b1;
                  end
               end
            end
         end
         spa_pkg::SPA_S_RESP: begin
            if (RESP_READY) begin
               rv_nxt = 1'b0;
               st_nxt = spa_pkg::SPA_S_IDLE;
            end
         end
         default: begin
            st_nxt = spa_pkg::SPA_S_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_r    <= spa_pkg::SPA_S_IDLE;
         slot_r  <= '{kind: spa_pkg::SPA_K_READ, wbit: 1'b1};
         start_r <= 1'b0;
         acc_r   <= 1'b0;
         dm_r    <= 1'b0;
         err_r   <= 1'b0;
         byte_r  <= '0;
         sh_r    <= '0;
         pos_r   <= '0;
         ph_r    <= '0;
         bit_r   <= '0;
         rd0_r   <= 1'b0;
         rv_r    <= 1'b0;
         rd_r    <= '0;
      end else begin
         st_r    <= st_nxt;
         slot_r  <= slot_nxt;
         start_r <= start_nxt;
         acc_r   <= acc_nxt;
         dm_r    <= dm_nxt;
         err_r   <= err_nxt;
         byte_r  <= byte_nxt;
         sh_r    <= sh_nxt;
         pos_r   <= pos_nxt;
         ph_r    <= ph_nxt;
         bit_r   <= bit_nxt;
         rd0_r   <= rd0_nxt;
         rv_r    <= rv_nxt;
         rd_r    <= rd_nxt;
      end
   end

   assign SLOT_START = start_r;
   assign SLOT_REQ   = slot_r;
   assign RESP_VALID = rv_r;
   assign RESP_DATA  = rd_r;
   assign ACCEL_ON   = acc_r;
   assign DATA_MODE  = dm_r;

   // Checks
   property p_acc_cmd;
      @(posedge REF_CLK) disable iff (!RESET_N)
      (st_r == spa_pkg::SPA_S_IDLE && f_valid && !dm_r && (f_data & `SPA_CMD_MASK) == `SPA_ACC_VAL)
      |=> (acc_r == $past(f_data[`SPA_ACC_BIT])) && !rv_r && (st_r == spa_pkg::SPA_S_IDLE);
   endproperty
   a_acc_cmd: assert property (p_acc_cmd) else $error("accelerator control wrong");

   property p_accel_start;
      @(posedge REF_CLK) disable iff (!RESET_N)
      (st_r == spa_pkg::SPA_S_IDLE && f_valid && dm_r && acc_r && f_data != `SPA_CMD_CMD)
      |=> SLOT_START && SLOT_REQ.kind == spa_pkg::SPA_K_READ;
   endproperty
   a_accel_start: assert property (p_accel_start) else $error("accelerated byte did not start a read");

   // A reset slot also finishes in phase zero, so only read slots qualify
   property p_second_read;
      @(posedge REF_CLK) disable iff (!RESET_N)
      (st_r == spa_pkg::SPA_S_SLOT && SLOT_DONE && acc_r && ph_r == 2'h0 && slot_r.kind == spa_pkg::SPA_K_READ)
      |=> SLOT_START && SLOT_REQ.kind == spa_pkg::SPA_K_READ && ph_r == 2'h1;
   endproperty
   a_second_read: assert property (p_second_read) else $error("second read slot missing");

   property p_write_conf;
      @(posedge REF_CLK) disable iff (!RESET_N)
      (st_r == spa_pkg::SPA_S_SLOT && SLOT_DONE && acc_r && ph_r == 2'h1 && !rd0_r && !SLOT_RBIT && !err_r)
      |=> SLOT_START && SLOT_REQ.kind == spa_pkg::SPA_K_WRITE && SLOT_REQ.wbit == byte_r[{pos_r, 1'b1}];
   endproperty
   a_write_conf: assert property (p_write_conf) else $error("conflict did not write host path");

   property p_write_noresp;
      @(posedge REF_CLK) disable iff (!RESET_N)
      (st_r == spa_pkg::SPA_S_SLOT && SLOT_DONE && acc_r && ph_r == 2'h1 && rd0_r && SLOT_RBIT)
      |=> SLOT_REQ.wbit && err_r && sh_r[{pos_r, 1'b0}];
   endproperty
   a_write_noresp: assert property (p_write_noresp) else $error("no response not handled");

   property p_path_match;
      @(posedge REF_CLK) disable iff (!RESET_N)
      (st_r == spa_pkg::SPA_S_SLOT && acc_r && ph_r == 2'h2)
      |-> sh_r[{pos_r, 1'b1}] == slot_r.wbit;
   endproperty
   a_path_match: assert property (p_path_match) else $error("reported path differs from written");

   property p_err_sticky;
      @(posedge REF_CLK) disable iff (!RESET_N)
      (err_r && acc_r && st_r == spa_pkg::SPA_S_SLOT && ph_r == 2'h2) |-> slot_r.wbit;
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("path not one after error");

   // A taken answer is gone on the next edge, so no byte is sent twice
   property p_one_answer;
      @(posedge REF_CLK) disable iff (!RESET_N)
      (rv_r && RESP_READY) |=> !rv_r;
   endproperty
   a_one_answer: assert property (p_one_answer) else $error("answer byte repeated");

   property p_resp_hold;
      @(posedge REF_CLK) disable iff (!RESET_N)
      (rv_r && !RESP_READY) |=> rv_r && $stable(rd_r);
   endproperty
   a_resp_hold: assert property (p_resp_hold) else $error("answer byte dropped");

   property p_reset_resp;
      @(posedge REF_CLK) disable iff (!RESET_N)
      (st_r == spa_pkg::SPA_S_SLOT && SLOT_DONE && slot_r.kind == spa_pkg::SPA_K_RESET)
      |=> rv_r && rd_r == {`SPA_RST_HEAD, $past(SLOT_PRES)};
   endproperty
   a_reset_resp: assert property (p_reset_resp) else $error("reset answer wrong");

   property p_cov_pass_byte;
      @(posedge REF_CLK) disable iff (!RESET_N)
      acc_r && st_r == spa_pkg::SPA_S_SLOT ##[1:200] rv_r;
   endproperty
   c_cov_pass_byte: cover property (p_cov_pass_byte);

   property p_cov_conf;
      @(posedge REF_CLK) disable iff (!RESET_N)
      st_r == spa_pkg::SPA_S_SLOT && SLOT_DONE && acc_r && ph_r == 2'h1 && !rd0_r && !SLOT_RBIT;
   endproperty
   c_cov_conf: cover property (p_cov_conf);

   property p_cov_full;
      @(posedge REF_CLK) disable iff (!RESET_N)
      !HOST_READY;
   endproperty
   c_cov_full: cover property (p_cov_full);
endmodule

// file: shared/spa_defines.svh
// Constants of the search path accelerator
`ifndef SPA_DEFINES_SVH
`define SPA_DEFINES_SVH
`define SPA_CMD_DATA   8'he1
`define SPA_CMD_CMD    8'he3
`define SPA_CMD_MASK   8'he3
`define SPA_ACC_VAL    8'ha1
`define SPA_RST_VAL    8'hc1
`define SPA_ACC_BIT    4
`define SPA_RST_HEAD   6'h33
`define SPA_POS_LAST   2'h3
`define SPA_BIT_LAST   3'h7
`define SPA_FIFO_W     8
`define SPA_FIFO_D     32
`define SPA_FIFO_AW    5
`endif

// file: shared/spa_pkg.sv
// Types of the search path accelerator
package spa_pkg;
   // Kind of single-wire bus activity
   typedef enum logic [1:0] {
      SPA_K_RESET = 2'h0,
      SPA_K_READ  = 2'h1,
      SPA_K_WRITE = 2'h2
   } spa_kind_t;
   // One slot request towards the slot engine
   typedef struct packed {
      spa_kind_t kind;
      logic      wbit;
   } spa_slot_t;
   // Sequencer states, Gray along idle, slot, answer
   typedef enum logic [1:0] {
      SPA_S_IDLE = 2'h0,
      SPA_S_SLOT = 2'h1,
      SPA_S_RESP = 2'h3
   } spa_state_t;
endpackage

// file: test/spa_bus_model.sv
// Behavioural single-wire bus: slot engine plus two search-capable devices
module spa_bus_model (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Slot engine handshake
   input  wire logic               slot_start,
   input  wire spa_pkg::spa_slot_t slot_req,
   output logic                    slot_done,
   output logic                    slot_rbit,
   output logic [1:0]              slot_pres,
   // Bus population and pacing
   input  wire logic [63:0]        rom_a,
   input  wire logic [63:0]        rom_b,
   input  wire logic [1:0]         present,
   input  wire logic               slow
);
   timeunit 1ns;
   timeprecision 1ps;
   spa_pkg::spa_slot_t req_r;  // Slot being served
   logic               busy_r;  // A slot is running
   logic [2:0]         wait_r;  // Extra cycles before done
   logic [1:0]         act_r;   // Devices still in the search
   logic [5:0]         pos_r;   // Identifier position
   logic [1:0]         rd_r;    // Reads seen since the last write

   // Serve one slot at a time; devices drop out when a write after reads differs from their bit
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {slot_done, busy_r, wait_r, act_r, pos_r, rd_r} <= '0;
         slot_rbit <= 1'b0;
         slot_pres <= 2'h0;
         req_r <= '0;
      end else begin
         slot_done <= 1'b0;
         // Outside a done pulse the answer lines wander, so a late sample is caught
         slot_rbit <= ~slot_rbit;
         slot_pres <= ~slot_pres;
         if (slot_start) begin
            busy_r <= 1'b1;
            req_r <= slot_req;
            wait_r <= slow ? 3'($urandom % 6) : 3'h0;
         end else if (busy_r && wait_r != 3'h0) begin
            wait_r <= wait_r - 3'h1;
         end else if (busy_r) begin
            busy_r <= 1'b0;
            slot_done <= 1'b1;
            case (req_r.kind)
               spa_pkg::SPA_K_RESET: begin
                  // Every present device answers and rejoins the search
                  act_r <= present;
                  pos_r <= 6'h0;
                  rd_r <= 2'h0;
                  slot_pres <= (present != 2'h0) ? 2'h1 : 2'h3;
               end
               spa_pkg::SPA_K_READ: begin
                  // Wired-AND: first read pulls low for a 0, second for a 1
                  slot_rbit <= !((act_r[0] && rom_a[pos_r] == rd_r[0]) || (act_r[1] && rom_b[pos_r] == rd_r[0]));
                  rd_r <= rd_r + 2'h1;
               end
               default: begin
                  // A write reads back its own level; after reads it selects
                  slot_rbit <= req_r.wbit;
                  if (rd_r != 2'h0) begin
                     if (rom_a[pos_r] != req_r.wbit) act_r[0] <= 1'b0;
                     if (rom_b[pos_r] != req_r.wbit) act_r[1] <= 1'b0;
                     pos_r <= pos_r + 6'h1;
                     rd_r <= 2'h0;
                  end
               end
            endcase
         end
      end
   end
endmodule

// file: test/search_path_accelerator_tb_top.sv
// Self-checking bench for the search path accelerator
module search_path_accelerator_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 80000;  // Cycle ceiling, well above the planned run
   logic               ref_clk = 1'b0;
   logic               reset_n = 1'b0;
   logic               host_valid = 1'b0;
   logic [7:0]         host_data = 8'h00;
   logic               resp_ready = 1'b0;
   logic               host_ready, resp_valid, slot_start, slot_done, slot_rbit, accel_on, data_mode;
   logic [7:0]         resp_data;
   logic [1:0]         slot_pres;
   spa_pkg::spa_slot_t slot_req;
   logic [63:0]        rom_a = '0;
   logic [63:0]        rom_b = '0;
   logic [1:0]         present = 2'h3;
   logic               slow = 1'b0;
   logic               hold = 1'b0;  // Holds answers back
   int                 num_errors = 0;
   int                 samples_checked = 0;
   int                 cyc = 0;
   logic [7:0]         exp_q[$];     // Answers still owed

   always #2.5 ref_clk = ~ref_clk;

   spa_top i_dut (.REF_CLK(ref_clk), .RESET_N(reset_n), .HOST_VALID(host_valid), .HOST_DATA(host_data),
      .HOST_READY(host_ready), .RESP_VALID(resp_valid), .RESP_DATA(resp_data), .RESP_READY(resp_ready),
      .SLOT_START(slot_start), .SLOT_REQ(slot_req), .SLOT_DONE(slot_done), .SLOT_RBIT(slot_rbit),
      .SLOT_PRES(slot_pres), .ACCEL_ON(accel_on), .DATA_MODE(data_mode));

   spa_bus_model i_bus (.clk(ref_clk), .rst_n(reset_n), .slot_start(slot_start), .slot_req(slot_req),
      .slot_done(slot_done), .slot_rbit(slot_rbit), .slot_pres(slot_pres), .rom_a(rom_a), .rom_b(rom_b),
      .present(present), .slow(slow));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Answer watcher: random back-pressure, oldest note compared per answer
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (resp_valid === 1'b1 && resp_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            num_errors++;
            $display("ERROR at %0t: answer %h not owed", $time, resp_data);
         end else check(resp_data, exp_q.pop_front());
      end
      resp_ready <= !hold && ($urandom % 4 != 0);
      if (cyc == LIMIT) begin
         num_errors++;
         $display("ERROR at %0t: run hung", $time);
         end_sim();
      end
   end

   // Offer one byte and hold it until taken
   task automatic put(input logic [7:0] b);
      host_valid <= 1'b1;
      host_data <= b;
      @(posedge ref_clk);
      while (host_ready !== 1'b1) @(posedge ref_clk);
      host_valid <= 1'b0;
      host_data <= 8'($urandom);
      @(posedge ref_clk);
   endtask

   // Wait for owed answers, let silent commands land, then look at status
   task automatic settle(input logic acc);
      for (int i = 0; i < 4000 && exp_q.size() != 0; i++) @(posedge ref_clk);
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      check({6'h0, accel_on, data_mode}, {6'h0, acc, 1'b0});
      @(posedge ref_clk);
   endtask

   // Expected answer bits of one pass: bit 2n flag, bit 2n+1 path
   function automatic logic [127:0] search_exp(input logic [63:0] r);
      logic [1:0]   act;
      logic         rd0, rd1, w, err;
      logic [127:0] res;
      act = present;
      err = 1'b0;
      for (int n = 0; n < 64; n++) begin
         rd0 = !((act[0] && !rom_a[n]) || (act[1] && !rom_b[n]));
         rd1 = !((act[0] && rom_a[n]) || (act[1] && rom_b[n]));
         err = err || (rd0 && rd1);
         w = err ? 1'b1 : (!rd0 && !rd1) ? r[n] : rd0;
         res[2*n] = (rd0 == rd1);
         res[2*n+1] = w;
         if (rom_a[n] != w) act[0] = 1'b0;
         if (rom_b[n] != w) act[1] = 1'b0;
      end
      return res;
   endfunction

   // One complete pass in the documented host order
   task automatic pass(input logic [63:0] r, output logic [127:0] res);
      logic [7:0] b;
      res = search_exp(r);
      exp_q.push_back({6'h33, (present != 2'h0) ? 2'h1 : 2'h3});
      put(8'hc1);
      put(8'he1);
      exp_q.push_back(8'hf0);
      put(8'hf0);
      put(8'he3);
      // The strong pullup is never armed by this bench
      put(8'hb1);
      settle(1'b1);
      put(8'he1);
      for (int k = 0; k < 16; k++) begin
         for (int j = 0; j < 4; j++) begin
            b[2*j] = 1'($urandom);
            b[2*j+1] = r[4*k+j];
         end
         // The mode switch code would leave data mode; only a filler bit changes
         if (b == 8'he3) b[0] = 1'b0;
         exp_q.push_back(res[8*k +: 8]);
         put(b);
      end
      put(8'he3);
      put(8'ha1);
      settle(1'b0);
   endtask

   initial begin
      logic [63:0]  r;
      logic [127:0] res;
      int           m, m_prev;
      logic         full;
      void'($urandom(85911));
      rom_a = {$urandom, $urandom};
      rom_b = rom_a ^ (64'h1 << ($urandom % 64)) ^ 64'h80;
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      check({host_ready, resp_valid, slot_start, accel_on, data_mode, 3'h0}, 8'h80);
      @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      // Host search loop: start all zero, advance on the highest discrepancy
      r = '0;
      m_prev = -1;
      for (int p = 0; p < 6; p++) begin
         pass(r, res);
         m = -1;
         for (int n = 0; n < 64; n++) if (res[2*n]) m = n;
         if (m < 0 || m == m_prev) break;
         r[m] = 1'b1;
         for (int i = m + 1; i < 64; i++) r[i] = 1'b0;
         m_prev = m;
         slow <= 1'b1;
      end
      // Empty bus: every position errors; the host repeats once one device is back
      present <= 2'h0;
      @(posedge ref_clk);
      pass(r, res);
      present <= 2'h1;
      @(posedge ref_clk);
      if (res[127] && res[126]) pass(r, res);
      // Fill the FIFO while answers are held back, then drain it
      hold <= 1'b1;
      put(8'he1);
      full = 1'b0;
      for (int i = 0; i < 40 && !full; i++) begin
         r[7:0] = 8'($urandom);
         // A random mode switch would be silent and owe no echo
         if (r[7:0] == 8'he3) r[7:0] = 8'h00;
         exp_q.push_back(r[7:0]);
         put(r[7:0]);
         @(negedge ref_clk);
         full = (host_ready === 1'b0);
         @(posedge ref_clk);
      end
      check({7'h0, full}, 8'h01);
      hold <= 1'b0;
      put(8'he3);
      settle(1'b0);
      check(8'(exp_q.size()), 8'h00);
      end_sim();
   end
endmodule
